// >>> core/xdec_ptr_alu.sv
// Purpose: pointer adder and subtractor for literal and offset arithmetic
// Assumes: operand b is unsigned
// Notes:   wraps modulo the pointer width, no flags produced
`timescale 1ns/1ps
`include "xdec_cfg.svh"

module xdec_ptr_alu
(
   xdec_alu_if.alu port_if
);

   logic [`XDEC_PTR_W-1:0] b_ext;

   assign b_ext = {4'h0, port_if.b};
   // wraparound is intended: pointers behave as modular addresses
   assign port_if.y = port_if.sub ? (port_if.a - b_ext) : (port_if.a + b_ext);

endmodule

// >>> core/xdec_top.sv
// Purpose: decode and execute the extended literal and indexed instructions
// Assumes: instruction words, working register and stack top come from logic on clock_in
// Notes:   no status flag is ever written by this block
//
// Function
// [RULE_01] Pointer add and subtract with a 6-bit literal update the chosen pointer in one cycle, flags untouched.
// [RULE_02] Add with select 11 adds the literal to the stack pointer, then returns from the stack top, two cycles.
// [RULE_03] Subtract with select 11 subtracts from the stack pointer, then returns from the stack top, two cycles.
// [RULE_04] Word 0014 is a call through the working register taking two cycles and no flags.
// [RULE_05] Two-word moves: bit 7 picks absolute or indexed destination, 7-bit source offset, second word 1111.
// [RULE_06] Push literal writes the literal at the stack pointer and decrements it in one cycle.
// [RULE_07] All extended decoding is off after reset and works only while the enable bit is set; in S_MOVE2 the second move word is taken even with it clear.
// [RULE_08] The call pushes the return address, then jumps to upper latch bytes with the working register low.
`timescale 1ns/1ps
`include "xdec_cfg.svh"

module xdec_top
(
   input  wire logic                     clock_in,
   input  wire logic                     rst_b_in,
   input  wire logic                     ext_enable_cfg_in,
   input  wire logic                     instr_valid_in,
   input  wire logic [15:0]              instr_word_in,
   input  wire logic [7:0]               working_reg_in,
   input  wire logic [`XDEC_UPPER_W-1:0] pc_latch_upper_in,
   input  wire logic [`XDEC_PC_W-1:0]    pc_next_in,
   input  wire logic [`XDEC_PC_W-1:0]    stack_top_in,
   input  wire logic [7:0]               mem_rdata_in,
   output logic                          ext_taken_out,
   output logic                          busy_out,
   output logic [`XDEC_PTR_W-1:0]        ptr0_out,
   output logic [`XDEC_PTR_W-1:0]        ptr1_out,
   output logic [`XDEC_PTR_W-1:0]        ptr2_out,
   output logic                          pc_load_out,
   output logic [`XDEC_PC_W-1:0]         pc_value_out,
   output logic                          stack_push_out,
   output logic [`XDEC_PC_W-1:0]         stack_push_data_out,
   output logic                          stack_pop_out,
   output logic                          mem_rd_out,
   output logic [`XDEC_PTR_W-1:0]        mem_raddr_out,
   output logic                          mem_wr_out,
   output logic [`XDEC_PTR_W-1:0]        mem_waddr_out,
   output logic [7:0]                    mem_wdata_out,
   output logic                          move_error_out
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic xdec_pkg::xdec_op_t xdec_decode(input logic [15:0] w);
      xdec_pkg::xdec_op_t op;
      op = xdec_pkg::OP_NONE;
      if (w == `XDEC_CALL_VIA_WORKING_REG_WORD)
         op = xdec_pkg::OP_CALL_VIA_WORKING_REG; // RULE_04
      else if (w[15:8] == `XDEC_PFX_ADD)
         op = (w[`XDEC_SEL_HI:`XDEC_SEL_LO] == `XDEC_SEL_STACK) ? xdec_pkg::OP_ADDRET : xdec_pkg::OP_ADD;
      else if (w[15:8] == `XDEC_PFX_SUB)
         op = (w[`XDEC_SEL_HI:`XDEC_SEL_LO] == `XDEC_SEL_STACK) ? xdec_pkg::OP_SUBRET : xdec_pkg::OP_SUB;
      else if (w[15:8] == `XDEC_PFX_PUSH)
         op = xdec_pkg::OP_PUSH;
      else if (w[15:8] == `XDEC_PFX_MOVE)
         op = w[`XDEC_MOVE_KIND] ? xdec_pkg::OP_INDEXED_TO_INDEXED_MOVE : xdec_pkg::OP_INDEXED_TO_ABSOLUTE_MOVE; // RULE_05
      return op;
   endfunction

   xdec_pkg::xdec_st_t st;
   xdec_pkg::xdec_st_t next_st;
   xdec_pkg::xdec_op_t cur_op;
   logic               take;
   logic [1:0]         sel;

   xdec_alu_if alu_if ();

   xdec_ptr_alu u_alu
   (
      .port_if (alu_if.alu)
   );

   // only a latched enable opens decoding, cleared by reset
   assign take   = instr_valid_in && (st.state == xdec_pkg::S_IDLE) && st.ext_en; // RULE_07
   assign cur_op = take ? xdec_decode(instr_word_in) : xdec_pkg::OP_NONE;
   assign sel    = instr_word_in[`XDEC_SEL_HI:`XDEC_SEL_LO];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st            = st;
      next_st.ext_en     = ext_enable_cfg_in;
      next_st.pc_load    = 1'b0;
      next_st.stack_push = 1'b0;
      next_st.stack_pop  = 1'b0;
      next_st.mem_rd     = 1'b0;
      next_st.mem_wr     = 1'b0;
      next_st.move_err   = 1'b0;
      alu_if.a           = st.ptr[`XDEC_STACK_PTR];
      alu_if.b           = `XDEC_BYTE_RESET;
      alu_if.sub         = 1'b0;
      unique case (st.state)
         xdec_pkg::S_IDLE:
         begin
            unique case (cur_op)
               xdec_pkg::OP_ADD, xdec_pkg::OP_SUB:
               begin
                  alu_if.a         = st.ptr[sel];
                  alu_if.b         = {2'b00, instr_word_in[5:0]};
                  alu_if.sub       = (cur_op == xdec_pkg::OP_SUB); // RULE_01
                  next_st.ptr[sel] = alu_if.y; // RULE_01
               end
               xdec_pkg::OP_ADDRET, xdec_pkg::OP_SUBRET:
               begin
                  alu_if.b                    = {2'b00, instr_word_in[5:0]};
                  alu_if.sub                  = (cur_op == xdec_pkg::OP_SUBRET); // RULE_03
                  next_st.ptr[`XDEC_STACK_PTR] = alu_if.y; // RULE_02
                  next_st.state               = xdec_pkg::S_RET;
               end
               xdec_pkg::OP_CALL_VIA_WORKING_REG:
               begin
                  next_st.stack_push = 1'b1; // RULE_08
                  next_st.push_data  = pc_next_in;
                  next_st.working_register_sav   = working_reg_in;
                  next_st.upper_sav  = pc_latch_upper_in;
                  next_st.state      = xdec_pkg::S_CALL2;
               end
               xdec_pkg::OP_INDEXED_TO_ABSOLUTE_MOVE, xdec_pkg::OP_INDEXED_TO_INDEXED_MOVE:
               begin
                  alu_if.b         = {1'b0, instr_word_in[6:0]}; // RULE_05
                  next_st.mem_rd   = 1'b1;
                  next_st.raddr    = alu_if.y;
                  next_st.move_ind = instr_word_in[`XDEC_MOVE_KIND];
                  next_st.state    = xdec_pkg::S_MOVE2;
               end
               xdec_pkg::OP_PUSH:
               begin
                  next_st.mem_wr               = 1'b1; // RULE_06
                  next_st.waddr                = st.ptr[`XDEC_STACK_PTR];
                  next_st.wdata                = instr_word_in[7:0];
                  alu_if.b                     = `XDEC_DEC_STEP;
                  alu_if.sub                   = 1'b1;
                  next_st.ptr[`XDEC_STACK_PTR] = alu_if.y; // RULE_06
               end
               xdec_pkg::OP_NONE:
               begin
                  next_st.state = xdec_pkg::S_IDLE;
               end
            endcase
         end
         xdec_pkg::S_RET:
         begin
            next_st.pc_load   = 1'b1; // RULE_02
            next_st.pc_value  = stack_top_in; // RULE_03
            next_st.stack_pop = 1'b1;
            next_st.state     = xdec_pkg::S_IDLE;
         end
         xdec_pkg::S_CALL2:
         begin
            next_st.pc_load  = 1'b1;
            next_st.pc_value = {st.upper_sav, st.working_register_sav}; // RULE_08
            next_st.state    = xdec_pkg::S_IDLE;
         end
         xdec_pkg::S_MOVE2:
         begin
            // read data is held in case the second word arrives late
            if (st.mem_rd)
               next_st.hold = mem_rdata_in;
            if (instr_valid_in)
            begin
               if (instr_word_in[15:12] == `XDEC_SECOND_NIB)
               begin
                  next_st.mem_wr = 1'b1; // RULE_05
                  next_st.wdata  = st.mem_rd ? mem_rdata_in : st.hold;
                  if (st.move_ind)
                  begin
                     alu_if.b      = {1'b0, instr_word_in[6:0]};
                     next_st.waddr = alu_if.y;
                  end
                  else
                     next_st.waddr = instr_word_in[11:0];
               end
               else
                  next_st.move_err = 1'b1;
               next_st.state = xdec_pkg::S_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         st           <= '0;
         st.state     <= xdec_pkg::S_IDLE;
         st.ext_en    <= 1'b0; // RULE_07
         st.ptr       <= {3{`XDEC_PTR_RESET}};
         st.pc_value  <= `XDEC_PC_RESET;
         st.push_data <= `XDEC_PC_RESET;
         st.upper_sav <= `XDEC_UPPER_RESET;
      end
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign ext_taken_out       = (cur_op != xdec_pkg::OP_NONE) || ((st.state == xdec_pkg::S_MOVE2) && instr_valid_in);
   assign busy_out            = (st.state == xdec_pkg::S_RET) || (st.state == xdec_pkg::S_CALL2);
   assign ptr0_out            = st.ptr[0];
   assign ptr1_out            = st.ptr[1];
   assign ptr2_out            = st.ptr[2];
   assign pc_load_out         = st.pc_load;
   assign pc_value_out        = st.pc_value;
   assign stack_push_out      = st.stack_push;
   assign stack_push_data_out = st.push_data;
   assign stack_pop_out       = st.stack_pop;
   assign mem_rd_out          = st.mem_rd;
   assign mem_raddr_out       = st.raddr;
   assign mem_wr_out          = st.mem_wr;
   assign mem_waddr_out       = st.waddr;
   assign mem_wdata_out       = st.wdata;
   assign move_error_out      = st.move_err;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_return_step;
      (st.state == xdec_pkg::S_RET) ##1 (pc_load_out && stack_pop_out && (pc_value_out == $past(stack_top_in)));
   endsequence

   sequence s_call_step;
      (stack_push_out && (stack_push_data_out == $past(pc_next_in)))
      ##1 (pc_load_out && (pc_value_out == {$past(pc_latch_upper_in, 2), $past(working_reg_in, 2)}));
   endsequence

   chk_add_ptr_zero : assert property ( // RULE_01
      (cur_op == xdec_pkg::OP_ADD) && (sel == 2'b00)
      |=> (ptr0_out == $past(ptr0_out) + 12'($past(instr_word_in[5:0]))) && $stable(ptr1_out))
      else $error("pointer 0 add wrong");

   chk_sub_ptr_one : assert property ( // RULE_01
      (cur_op == xdec_pkg::OP_SUB) && (sel == 2'b01)
      |=> (ptr1_out == $past(ptr1_out) - 12'($past(instr_word_in[5:0]))) && !pc_load_out)
      else $error("pointer 1 subtract wrong");

   chk_add_return : assert property ( // RULE_02
      (cur_op == xdec_pkg::OP_ADDRET)
      |=> (ptr2_out == $past(ptr2_out) + 12'($past(instr_word_in[5:0]))) ##0 s_return_step)
      else $error("add and return sequence wrong");

   chk_sub_return : assert property ( // RULE_03
      (cur_op == xdec_pkg::OP_SUBRET)
      |=> (ptr2_out == $past(ptr2_out) - 12'($past(instr_word_in[5:0]))) ##0 s_return_step)
      else $error("subtract and return sequence wrong");

   chk_call_target : assert property ( // RULE_08
      (cur_op == xdec_pkg::OP_CALL_VIA_WORKING_REG) |=> s_call_step)
      else $error("call through working register wrong");

   chk_call_length : assert property ( // RULE_04
      (cur_op == xdec_pkg::OP_CALL_VIA_WORKING_REG) |=> busy_out ##1 (!busy_out && (st.state == xdec_pkg::S_IDLE)))
      else $error("call not two cycles");

   chk_move_write : assert property ( // RULE_05
      (st.state == xdec_pkg::S_MOVE2) && instr_valid_in && (instr_word_in[15:12] == `XDEC_SECOND_NIB)
      |=> mem_wr_out && !move_error_out && (st.state == xdec_pkg::S_IDLE))
      else $error("move second word not written");

   chk_push_literal : assert property ( // RULE_06
      (cur_op == xdec_pkg::OP_PUSH)
      |=> mem_wr_out && (mem_wdata_out == $past(instr_word_in[7:0])) && (mem_waddr_out == $past(ptr2_out))
          && (ptr2_out == $past(ptr2_out) - 12'h001))
      else $error("push literal wrong");

   chk_disabled_quiet : assert property ( // RULE_07
      !st.ext_en |-> !ext_taken_out && (st.state == xdec_pkg::S_IDLE))
      else $error("decoding while extension disabled");

endmodule

// >>> inc/xdec_alu_if.sv
// Purpose: carrier between the sequencer and the pointer adder
// Assumes: one operation per cycle
// Notes:   purely combinational signals
`timescale 1ns/1ps
`include "xdec_cfg.svh"

interface xdec_alu_if;
   logic [`XDEC_PTR_W-1:0] a;
   logic [7:0]             b;
   logic                   sub;
   logic [`XDEC_PTR_W-1:0] y;

   modport user (output a, output b, output sub, input y);
   modport alu  (input a, input b, input sub, output y);
endinterface

// >>> inc/xdec_cfg.svh
// Purpose: constants of the extended instruction decoder
// Assumes: 16-bit instruction words, 12-bit data pointers, 21-bit program counter
// Notes:   definitions only
`ifndef XDEC_CFG_SVH
`define XDEC_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define XDEC_PTR_W        12
`define XDEC_PC_W         21
`define XDEC_UPPER_W      13

// ----------------------------------------------------------------
// opcode encodings and field positions
// ----------------------------------------------------------------
`define XDEC_PFX_ADD      8'hE8
`define XDEC_PFX_SUB      8'hE9
`define XDEC_PFX_PUSH     8'hEA
`define XDEC_PFX_MOVE     8'hEB
`define XDEC_CALL_VIA_WORKING_REG_WORD   16'h0014
`define XDEC_SECOND_NIB   4'hF
`define XDEC_SEL_STACK    2'h3
`define XDEC_SEL_HI       7
`define XDEC_SEL_LO       6
`define XDEC_MOVE_KIND    7
`define XDEC_STACK_PTR    2

// ----------------------------------------------------------------
// reset values and steps
// ----------------------------------------------------------------
`define XDEC_PTR_RESET    12'h000
`define XDEC_PC_RESET     21'h00_0000
`define XDEC_BYTE_RESET   8'h00
`define XDEC_UPPER_RESET  13'h0000
`define XDEC_DEC_STEP     8'h01

`endif

// >>> inc/xdec_pkg.sv
// Purpose: types of the extended instruction decoder
// Assumes: xdec_cfg.svh supplies widths
// Notes:   whole module state is one packed struct
`include "xdec_cfg.svh"

package xdec_pkg;

   // ----------------------------------------------------------------
   // decoded operations and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE   = 4'b0000,
      OP_ADD    = 4'b0001,
      OP_SUB    = 4'b0010,
      OP_ADDRET = 4'b0011,
      OP_SUBRET = 4'b0100,
      OP_CALL_VIA_WORKING_REG  = 4'b0101,
      OP_INDEXED_TO_ABSOLUTE_MOVE  = 4'b0110,
      OP_INDEXED_TO_INDEXED_MOVE  = 4'b0111,
      OP_PUSH   = 4'b1000
   } xdec_op_t;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_RET   = 2'b01,
      S_CALL2 = 2'b10,
      S_MOVE2 = 2'b11
   } xdec_state_t;

   // ----------------------------------------------------------------
   // module state
   // ----------------------------------------------------------------
   typedef struct packed {
      xdec_state_t                         state;
      logic                                ext_en;
      logic [2:0][`XDEC_PTR_W-1:0]         ptr;
      logic                                pc_load;
      logic [`XDEC_PC_W-1:0]               pc_value;
      logic                                stack_push;
      logic [`XDEC_PC_W-1:0]               push_data;
      logic                                stack_pop;
      logic                                mem_rd;
      logic [`XDEC_PTR_W-1:0]              raddr;
      logic                                mem_wr;
      logic [`XDEC_PTR_W-1:0]              waddr;
      logic [7:0]                          wdata;
      logic [7:0]                          hold;
      logic                                move_ind;
      logic [7:0]                          working_register_sav;
      logic [`XDEC_UPPER_W-1:0]            upper_sav;
      logic                                move_err;
   } xdec_st_t;

endpackage

// >>> tb/xdec_top_test.sv
// Purpose: self-checking bench for the extended instruction decoder
// Assumes: inputs driven 2 ns after the rising edge, outputs sampled once settled
// Notes:   pointer expectations follow on from one row to the next
`timescale 1ns/1ps
`include "xdec_cfg.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
   $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end

module xdec_top_test;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                     clock_in, rst_b_in, ext_enable_cfg_in, instr_valid_in;
   logic [15:0]              instr_word_in;
   logic [7:0]               working_reg_in, mem_rdata_in;
   logic [`XDEC_UPPER_W-1:0] pc_latch_upper_in;
   logic [`XDEC_PC_W-1:0]    pc_next_in, stack_top_in, pc_value_out, stack_push_data_out;
   logic                     ext_taken_out, busy_out, pc_load_out, stack_push_out, stack_pop_out;
   logic                     mem_rd_out, mem_wr_out, move_error_out;
   logic [`XDEC_PTR_W-1:0]   ptr0_out, ptr1_out, ptr2_out, mem_raddr_out, mem_waddr_out;
   logic [7:0]               mem_wdata_out;
   int                       num_errors, comparisons, cycles;
   logic                     tk;

   typedef struct {
      logic [15:0]            word;
      logic                   taken;
      logic [`XDEC_PTR_W-1:0] p0, p1, p2;
      logic                   wr;
      logic [`XDEC_PTR_W-1:0] waddr;
      logic [7:0]             wdata;
   } xdec_row_t;

   // one word per cycle, back to back; pointers start at zero
   xdec_row_t rows [8] = '{
      '{16'hE83F, 1'b1, 12'h03F, 12'h000, 12'h000, 1'b0, 12'h000, 8'h00},
      '{16'hE941, 1'b1, 12'h03F, 12'hFFF, 12'h000, 1'b0, 12'h000, 8'h00},
      '{16'hE8BF, 1'b1, 12'h03F, 12'hFFF, 12'h03F, 1'b0, 12'h000, 8'h00},
      '{16'hE905, 1'b1, 12'h03A, 12'hFFF, 12'h03F, 1'b0, 12'h000, 8'h00},
      '{16'hEAAA, 1'b1, 12'h03A, 12'hFFF, 12'h03E, 1'b1, 12'h03F, 8'hAA},
      '{16'hEA00, 1'b1, 12'h03A, 12'hFFF, 12'h03D, 1'b1, 12'h03E, 8'h00},
      '{16'h0015, 1'b0, 12'h03A, 12'hFFF, 12'h03D, 1'b0, 12'h000, 8'h00},
      '{16'h1234, 1'b0, 12'h03A, 12'hFFF, 12'h03D, 1'b0, 12'h000, 8'h00}
   };

   xdec_top u_xdec_top (.clock_in(clock_in), .rst_b_in(rst_b_in), .ext_enable_cfg_in(ext_enable_cfg_in),
      .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in), .working_reg_in(working_reg_in),
      .pc_latch_upper_in(pc_latch_upper_in), .pc_next_in(pc_next_in), .stack_top_in(stack_top_in),
      .mem_rdata_in(mem_rdata_in), .ext_taken_out(ext_taken_out), .busy_out(busy_out),
      .ptr0_out(ptr0_out), .ptr1_out(ptr1_out), .ptr2_out(ptr2_out), .pc_load_out(pc_load_out),
      .pc_value_out(pc_value_out), .stack_push_out(stack_push_out),
      .stack_push_data_out(stack_push_data_out), .stack_pop_out(stack_pop_out), .mem_rd_out(mem_rd_out),
      .mem_raddr_out(mem_raddr_out), .mem_wr_out(mem_wr_out), .mem_waddr_out(mem_waddr_out),
      .mem_wdata_out(mem_wdata_out), .move_error_out(move_error_out));

   // ----------------------------------------------------------------
   // clock and timeout
   // ----------------------------------------------------------------
   initial
   begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end

   // whole run is under 100 cycles; a hang runs on until this 500-cycle ceiling stops it
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 500)
      begin
         num_errors++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic tick();
      @(posedge clock_in);
      #2;
   endtask

   task automatic op(input logic [15:0] w, output logic taken);
      instr_valid_in = 1'b1;
      instr_word_in  = w;
      #8;
      taken = ext_taken_out;
      tick();
      instr_valid_in = 1'b0;
   endtask

   // reset clears everything and the first word after release is still refused
   task automatic do_reset();
      rst_b_in = 1'b0;
      // check on the next falling edge: the reset is asynchronous, so the outputs are already cleared
      @(negedge clock_in);
      `CHK({ptr0_out, ptr1_out, ptr2_out, pc_value_out, pc_load_out, mem_wr_out}, '0)
      repeat (3) tick();
      rst_b_in = 1'b1;
      op(16'hE801, tk);
      `CHK({tk, ptr0_out}, {1'b0, 12'h000})
   endtask

   task automatic ret_op(input logic [15:0] w, input logic [20:0] top, input logic [11:0] p2);
      stack_top_in   = top;
      instr_valid_in = 1'b1;
      instr_word_in  = w;
      #8;
      `CHK(ext_taken_out, 1'b1)
      tick();
      `CHK({busy_out, ptr2_out, pc_load_out}, {1'b1, p2, 1'b0})
      instr_word_in = 16'hE801;
      #8;
      `CHK(ext_taken_out, 1'b0)
      tick();
      instr_valid_in = 1'b0;
      `CHK({pc_load_out, stack_pop_out, pc_value_out, busy_out, ptr0_out}, {2'b11, top, 1'b0, 12'h03A})
      tick();
      `CHK({pc_load_out, stack_pop_out}, 2'b00)
   endtask

   // second word arrives one cycle late, read data gone by then
   task automatic move(input logic [15:0] w1, input logic [15:0] w2, input logic [7:0] rd,
                       input logic [11:0] raddr, input logic ok, input logic [11:0] waddr);
      op(w1, tk);
      mem_rdata_in = rd;
      `CHK({tk, mem_rd_out, mem_raddr_out}, {2'b11, raddr})
      tick();
      mem_rdata_in = ~rd;
      op(w2, tk);
      `CHK({tk, mem_wr_out, move_error_out}, {1'b1, ok, ~ok})
      if (ok) `CHK({mem_waddr_out, mem_wdata_out}, {waddr, rd})
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_b_in, instr_valid_in, instr_word_in, working_reg_in, mem_rdata_in} = '0;
      {pc_latch_upper_in, pc_next_in, stack_top_in} = '0;
      ext_enable_cfg_in = 1'b1;
      do_reset();
      for (int i = 0; i < 8; i++)
      begin
         instr_valid_in = 1'b1;
         instr_word_in  = rows[i].word;
         #8;
         `CHK(ext_taken_out, rows[i].taken)
         tick();
         `CHK({ptr0_out, ptr1_out, ptr2_out}, {rows[i].p0, rows[i].p1, rows[i].p2})
         `CHK({mem_wr_out, pc_load_out}, {rows[i].wr, 1'b0})
         if (rows[i].wr) `CHK({mem_waddr_out, mem_wdata_out}, {rows[i].waddr, rows[i].wdata})
      end
      instr_valid_in = 1'b0;
      ret_op(16'hE8C3, 21'h1_2345, 12'h040);
      ret_op(16'hE9FF, 21'h0_0ABC, 12'h001);
      working_reg_in    = 8'h5A;
      pc_latch_upper_in = 13'h1ABC;
      pc_next_in        = 21'h0_4321;
      op(16'h0014, tk);
      working_reg_in = 8'hC3;
      `CHK({tk, stack_push_out, stack_push_data_out, busy_out}, {2'b11, 21'h0_4321, 1'b1})
      tick();
      `CHK({pc_load_out, pc_value_out, stack_push_out}, {1'b1, 13'h1ABC, 8'h5A, 1'b0})
      `CHK(busy_out, 1'b0)
      move(16'hEB05, 16'hF123, 8'h77, 12'h006, 1'b1, 12'h123);
      move(16'hEB85, 16'hFF8A, 8'h3C, 12'h006, 1'b1, 12'h00B);
      move(16'hEB01, 16'h0123, 8'h55, 12'h002, 1'b0, 12'h000);
      ext_enable_cfg_in = 1'b0;
      tick();
      op(16'hE801, tk);
      `CHK({tk, ptr0_out}, {1'b0, 12'h03A})
      ext_enable_cfg_in = 1'b1;
      tick();
      op(16'hE801, tk);
      `CHK({tk, ptr0_out}, {1'b1, 12'h03B})
      do_reset();
      end_of_test();
   end
endmodule
